// [cps_config_port.sv]
// configuration data port: async peripheral, slave serial, slave parallel, readback
//
// Summary of operation
// - async mode shows not-ready on the ready pin and on data bit 7 during reads.
// - async bytes shift out on the chain output on config clock falling edges.
// - during async reads only data bit 7 is driven; bits 6..0 stay inputs.
// - slave serial bits go to the chain output on the next falling edge.
// - slave parallel mode passes nothing downstream; chain output stays idle.
// - parallel chip selects and write strobe are sampled on config clock rising edges.
// - readback control high for two config clock cycles aborts a running readback.
// - the restart input clears configuration back to its beginning.
`timescale 1ns/10ps
module cps_config_port #(
   parameter int DATA_W = cps_pkg::BYTE_W,
   parameter int FIFO_DEPTH = cps_pkg::FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [1:0] mode,
   input wire logic restart_n,
   input wire logic config_clock,
   input wire logic chip_select_low_active_n,
   input wire logic chip_select_high_active,
   input wire logic write_n,
   input wire logic read_n,
   input wire logic [DATA_W-1:0] data_in,
   input wire logic serial_in,
   input wire logic readback_ctrl,
   output logic chain_out,
   output logic ready,
   output logic status_data_bit_seven_out,
   output logic status_data_bit_seven_oe_n,
   output logic overflow,
   output logic [DATA_W-1:0] cfg_data,
   output logic cfg_valid,
   input wire logic cfg_ready,
   input wire logic rb_start,
   input wire logic [DATA_W-1:0] rb_byte,
   input wire logic rb_valid,
   output logic rb_ready,
   output logic readback_data,
   output logic readback_busy,
   output logic readback_aborted
);
   localparam int SYNC_W = DATA_W + 10;
   logic [SYNC_W-1:0] pins_s;
   logic [1:0] mode_s;
   logic restart_n_s;
   logic config_clock_s;
   logic csl_n_s;
   logic csh_s;
   logic wr_n_s;
   logic rd_n_s;
   logic [DATA_W-1:0] data_s;
   logic sin_s;
   logic rbc_s;
   logic restart;
   logic config_clock_d;
   logic config_clock_rise;
   logic config_clock_fall;
   logic selected;
   logic wr_act;
   logic wr_act_d;
   logic wr_end;
   logic [DATA_W-1:0] wr_data;
   logic [DATA_W-1:0] shift_reg;
   logic [cps_pkg::CNT_W-1:0] shift_cnt;
   logic [DATA_W-1:0] ser_byte;
   logic [2:0] ser_cnt;
   logic ser_bit;
   logic ser_pending;
   logic src_fire;
   logic [DATA_W-1:0] src_data;
   logic push_valid;
   logic [DATA_W-1:0] push_data;
   logic fifo_in_ready;
   cps_pkg::cps_rb_state_t rb_state;
   cps_pkg::cps_rb_state_t next_rb_state;
   logic [DATA_W-1:0] rb_shift;
   logic [cps_pkg::CNT_W-1:0] rb_cnt;
   logic [cps_pkg::ABORT_W-1:0] abort_cnt;
   logic abort_hit;

   function automatic logic is_mode(input logic [1:0] cur, input logic [1:0] want);
      return cur == want;
   endfunction

   // every pin crosses into clk_sys through two flops
   cps_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .d({mode, restart_n, config_clock, chip_select_low_active_n, chip_select_high_active,
          write_n, read_n, data_in, serial_in, readback_ctrl}),
      .q(pins_s)
   );

   assign {mode_s, restart_n_s, config_clock_s, csl_n_s, csh_s, wr_n_s, rd_n_s, data_s, sin_s,
           rbc_s} = pins_s;

   assign restart = !restart_n_s;
   // the config clock comes from outside and is only sampled here
   assign config_clock_rise = config_clock_s && !config_clock_d;
   assign config_clock_fall = !config_clock_s && config_clock_d;
   assign selected = !csl_n_s && csh_s;
   assign wr_act = selected && !wr_n_s;
   assign wr_end = wr_act_d && !wr_act;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         config_clock_d <= 1'b0;
         wr_act_d <= 1'b0;
      end else begin
         config_clock_d <= config_clock_s;
         wr_act_d <= wr_act;
      end
   end
   // data hold is zero, so keep the last byte seen while the strobe was active
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wr_data <= '0;
      end else if (wr_act) begin
         wr_data <= data_s;
      end
   end

   // async peripheral: byte taken at the end of the write strobe
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         shift_reg <= '0;
         shift_cnt <= '0;
      end else if (restart) begin
         shift_reg <= '0;
         shift_cnt <= '0;
      end else if (is_mode(mode_s, cps_pkg::MODE_ASYNC) && wr_end && ready) begin
         shift_reg <= wr_data;
         shift_cnt <= cps_pkg::BITS_PER_BYTE;
      end else if (config_clock_fall && shift_cnt != '0) begin
         shift_reg <= {shift_reg[DATA_W-2:0], 1'b0};
         shift_cnt <= shift_cnt - cps_pkg::CNT_W'(1);
      end
   end

   // ready falls while the byte serialises or waits for fifo room
   assign ready = !restart && shift_cnt == '0 && !push_valid;
   // slave serial: capture on rise, forward on the following fall
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ser_byte <= '0;
         ser_cnt <= '0;
         ser_bit <= 1'b0;
         ser_pending <= 1'b0;
      end else if (restart || !is_mode(mode_s, cps_pkg::MODE_SERIAL)) begin
         ser_cnt <= '0;
         ser_pending <= 1'b0;
      end else if (config_clock_rise) begin
         ser_byte <= {ser_byte[DATA_W-2:0], sin_s};
         ser_cnt <= ser_cnt + 3'(1);
         ser_bit <= sin_s;
         ser_pending <= 1'b1;
      end else if (config_clock_fall) begin
         ser_pending <= 1'b0;
      end
   end

   // one byte source per mode feeds the push register
   always_comb begin
      src_fire = 1'b0;
      src_data = data_s;
      case (mode_s)
         cps_pkg::MODE_ASYNC: begin
            src_fire = wr_end && ready && !restart;
            src_data = wr_data;
         end
         cps_pkg::MODE_SERIAL: begin
            src_fire = config_clock_rise && ser_cnt == cps_pkg::LAST_SERIAL_BIT && !restart;
            src_data = {ser_byte[DATA_W-2:0], sin_s};
         end
         cps_pkg::MODE_PARALLEL: begin
            // strobes are taken only at the config clock rising edge
            src_fire = config_clock_rise && wr_act && !restart;
            src_data = data_s;
         end
         default: src_fire = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         push_valid <= 1'b0;
         push_data <= '0;
      end else if (restart) begin
         push_valid <= 1'b0;
      end else if (src_fire && (!push_valid || fifo_in_ready)) begin
         push_valid <= 1'b1;
         push_data <= src_data;
      end else if (fifo_in_ready) begin
         push_valid <= 1'b0;
      end
   end
   // a byte arriving while the previous one is still stalled is lost
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         overflow <= 1'b0;
      end else if (src_fire && push_valid && !fifo_in_ready) begin
         overflow <= 1'b1;
      end else if (restart) begin
         overflow <= 1'b0;
      end
   end

   cps_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .clear(restart),
      .in_data(push_data),
      .in_valid(push_valid),
      .in_ready(fifo_in_ready),
      .out_data(cfg_data),
      .out_valid(cfg_valid),
      .out_ready(cfg_ready)
   );

   // daisy-chain output
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         chain_out <= cps_pkg::IDLE_LEVEL;
      end else if (restart) begin
         chain_out <= cps_pkg::IDLE_LEVEL;
      end else begin
         case (mode_s)
            cps_pkg::MODE_ASYNC: begin
               if (config_clock_fall && shift_cnt != '0) begin
                  chain_out <= shift_reg[DATA_W-1];
               end
            end
            cps_pkg::MODE_SERIAL: begin
               if (config_clock_fall && ser_pending) begin
                  chain_out <= ser_bit;
               end
            end
            default: chain_out <= cps_pkg::IDLE_LEVEL;
         endcase
      end
   end

   // status read: only bit 7 has a driver; bits 6..0 have no output at all
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         status_data_bit_seven_out <= 1'b0;
         status_data_bit_seven_oe_n <= 1'b1;
      end else begin
         status_data_bit_seven_out <= ready;
         status_data_bit_seven_oe_n <= !(is_mode(mode_s, cps_pkg::MODE_ASYNC) && selected
                                         && !rd_n_s);
      end
   end
   // abort counter: config clock rises seen with the control held high
   assign abort_hit = abort_cnt == cps_pkg::ABORT_CYCLES;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         abort_cnt <= '0;
      end else if (!rbc_s) begin
         abort_cnt <= '0;
      end else if (config_clock_rise && !abort_hit) begin
         abort_cnt <= abort_cnt + cps_pkg::ABORT_W'(1);
      end
   end

   always_comb begin
      next_rb_state = rb_state;
      case (rb_state)
         cps_pkg::RB_IDLE: begin
            if (rb_start) begin
               next_rb_state = cps_pkg::RB_LOAD;
            end
         end
         cps_pkg::RB_LOAD: begin
            if (rb_valid) begin
               next_rb_state = cps_pkg::RB_SHIFT;
            end
         end
         cps_pkg::RB_SHIFT: begin
            if (config_clock_fall && rb_cnt == cps_pkg::CNT_W'(1)) begin
               next_rb_state = cps_pkg::RB_LOAD;
            end
         end
         default: next_rb_state = cps_pkg::RB_IDLE;
      endcase
      if (restart || abort_hit) begin
         next_rb_state = cps_pkg::RB_IDLE;
      end
   end

   assign rb_ready = rb_state == cps_pkg::RB_LOAD && !restart && !abort_hit;
   assign readback_busy = rb_state != cps_pkg::RB_IDLE;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rb_state <= cps_pkg::RB_IDLE;
      end else begin
         rb_state <= next_rb_state;
      end
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         readback_aborted <= 1'b0;
      end else begin
         readback_aborted <= abort_hit && readback_busy;
      end
   end

   // readback shifter, msb first on config clock falls
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rb_shift <= '0;
         rb_cnt <= '0;
         readback_data <= cps_pkg::IDLE_LEVEL;
      end else if (next_rb_state == cps_pkg::RB_IDLE) begin
         rb_cnt <= '0;
         readback_data <= cps_pkg::IDLE_LEVEL;
      end else if (rb_ready && rb_valid) begin
         rb_shift <= rb_byte;
         rb_cnt <= cps_pkg::BITS_PER_BYTE;
      end else if (rb_state == cps_pkg::RB_SHIFT && config_clock_fall) begin
         readback_data <= rb_shift[DATA_W-1];
         rb_shift <= {rb_shift[DATA_W-2:0], 1'b0};
         rb_cnt <= rb_cnt - cps_pkg::CNT_W'(1);
      end
   end
endmodule

// [cps_config_port_checker.sv]
// concurrent checks on the configuration port pins and core handshakes
`timescale 1ns/10ps
module cps_config_port_checker #(
   parameter int DATA_W = 8
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [1:0] mode,
   input wire logic restart_n,
   input wire logic config_clock,
   input wire logic read_n,
   input wire logic readback_ctrl,
   input wire logic chain_out,
   input wire logic ready,
   input wire logic status_data_bit_seven_out,
   input wire logic status_data_bit_seven_oe_n,
   input wire logic [DATA_W-1:0] cfg_data,
   input wire logic cfg_valid,
   input wire logic cfg_ready,
   input wire logic readback_data,
   input wire logic readback_busy,
   input wire logic readback_aborted
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   logic [2:0] rs_cnt;
   logic rs_ok;
   // restart pin settled high long enough to have passed the synchroniser
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) rs_cnt <= 3'h0;
      else if (!restart_n) rs_cnt <= 3'h0;
      else if (rs_cnt != 3'h7) rs_cnt <= rs_cnt + 3'h1;
   end
   assign rs_ok = (rs_cnt == 3'h7);
   sequence restart_held_s;
      !restart_n [*5];
   endsequence
   sequence par_held_s;
      (mode == cps_pkg::MODE_PARALLEL) [*8];
   endsequence
   oe_needs_read_a: assert property (!status_data_bit_seven_oe_n |->
      $past(!read_n, 2) || $past(!read_n, 3) || $past(!read_n, 4)) else $error("bit7 driven");
   bit7_ready_a: assert property (!status_data_bit_seven_oe_n |->
      status_data_bit_seven_out == $past(ready)) else $error("bit7 not ready");
   ready_returns_a: assert property ($fell(ready) && restart_n &&
      mode == cps_pkg::MODE_ASYNC |-> ##[1:400] ready) else $error("ready stuck low");
   chain_after_fall_a: assert property ($changed(chain_out) && rs_ok &&
      $past(mode, 4) == mode |-> !$past(config_clock, 2) || !$past(config_clock, 3))
      else $error("chain moved off fall");
   rb_after_fall_a: assert property ($changed(readback_data) && readback_busy &&
      $past(readback_busy) |-> !$past(config_clock, 2) || !$past(config_clock, 3))
      else $error("readback moved off fall");
   abort_hold_a: assert property (readback_aborted |->
      $past(readback_ctrl, 4) && $past(readback_ctrl, 18)) else $error("abort too early");
   abort_idle_a: assert property (readback_aborted |->
      !readback_busy && readback_data) else $error("abort left readback busy");
   fifo_hold_a: assert property (cfg_valid && !cfg_ready && rs_ok |=>
      cfg_valid && $stable(cfg_data)) else $error("core word dropped");
   restart_clear_a: assert property (restart_held_s |-> !ready && !cfg_valid)
      else $error("restart did not clear");
   parallel_idle_a: assert property (par_held_s ##0 rs_ok |-> chain_out)
      else $error("chain active in parallel");
endmodule
bind cps_config_port cps_config_port_checker #(.DATA_W(DATA_W)) i_cps_config_port_checker (
   .clk_sys(clk_sys), .nrst(nrst), .mode(mode), .restart_n(restart_n),
   .config_clock(config_clock), .read_n(read_n), .readback_ctrl(readback_ctrl),
   .chain_out(chain_out), .ready(ready), .status_data_bit_seven_out(status_data_bit_seven_out),
   .status_data_bit_seven_oe_n(status_data_bit_seven_oe_n), .cfg_data(cfg_data),
   .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .readback_data(readback_data),
   .readback_busy(readback_busy), .readback_aborted(readback_aborted));

// [cps_fifo.sv]
// small valid/ready fifo; depth must be a power of two
`timescale 1ns/10ps
module cps_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic clear,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic full;

   // extra pointer bit tells full from empty
   assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign in_ready = !full;
   assign out_valid = (wr_ptr != rd_ptr);
   assign out_data = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clk_sys) begin
      if (in_valid && in_ready) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
      end else if (clear) begin
         wr_ptr <= '0;
      end else if (in_valid && in_ready) begin
         wr_ptr <= wr_ptr + (AW+1)'(1);
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rd_ptr <= '0;
      end else if (clear) begin
         rd_ptr <= '0;
      end else if (out_valid && out_ready) begin
         rd_ptr <= rd_ptr + (AW+1)'(1);
      end
   end
endmodule

// [cps_host_model.sv]
// upstream source model: config clock in frames and serial data
`timescale 1ns/10ps
module cps_host_model (
   output logic config_clock,
   output logic serial_in
);
   initial begin
      config_clock = 1'b0;
      serial_in = 1'b1;
   end
   // clock stands still between frames; slow stretches the low phase
   task automatic frame(input logic [7:0] b, input int n, input bit slow);
      for (int i = 0; i < n; i++) begin
         serial_in = b[7 - (i % 8)];
         #80 config_clock = 1'b1;
         #80 config_clock = 1'b0;
         if (slow) #240;
      end
      // released line: no longer shows the last bit
      serial_in = ~serial_in;
   endtask
endmodule

// [cps_pkg.sv]
// constants and types shared by the configuration port slave
package cps_pkg;
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 4;
   localparam int SYNC_STAGES = 2;
   // mode strap encodings
   localparam logic [1:0] MODE_ASYNC = 2'h0;
   localparam logic [1:0] MODE_SERIAL = 2'h1;
   localparam logic [1:0] MODE_PARALLEL = 2'h2;
   // bit counter width and load value for one byte
   localparam int CNT_W = 4;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [2:0] LAST_SERIAL_BIT = 3'h7;
   // config clock cycles that the readback control must stay high to abort
   localparam int ABORT_W = 2;
   localparam logic [1:0] ABORT_CYCLES = 2'h2;
   // idle level of the chain and readback outputs
   localparam logic IDLE_LEVEL = 1'b1;
   typedef enum logic [1:0] {
      RB_IDLE,
      RB_LOAD,
      RB_SHIFT
   } cps_rb_state_t;
endpackage

// [cps_sync.sv]
// two flip-flop synchroniser for a vector of external levels
`timescale 1ns/10ps
module cps_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   // meta is read only by q
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// [test_cps_config_port.sv]
// self-checking bench for the configuration port
`timescale 1ns/10ps
module test_cps_config_port;
   logic clk_sys, nrst, restart_n, cs_n, cs_hi, write_n, read_n, serial_in, config_clock;
   logic [1:0] mode;
   logic [7:0] data_in, cfg_data, rb_byte, ch_sh, rb_sh;
   logic readback_ctrl, chain_out, ready, b7_out, b7_oe_n, overflow, cfg_valid, cfg_ready;
   logic rb_start, rb_valid, rb_ready, rb_data, rb_busy, rb_abort;
   logic seen_abort = 1'b0;
   logic [7:0] got[$];
   int n_fail = 0;
   int n_compared = 0;
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   cps_host_model i_cps_host_model (.config_clock(config_clock), .serial_in(serial_in));
   cps_config_port i_cps_config_port (.clk_sys(clk_sys), .nrst(nrst), .mode(mode),
      .restart_n(restart_n), .config_clock(config_clock), .chip_select_low_active_n(cs_n),
      .chip_select_high_active(cs_hi), .write_n(write_n), .read_n(read_n), .data_in(data_in),
      .serial_in(serial_in), .readback_ctrl(readback_ctrl), .chain_out(chain_out),
      .ready(ready), .status_data_bit_seven_out(b7_out), .status_data_bit_seven_oe_n(b7_oe_n),
      .overflow(overflow), .cfg_data(cfg_data), .cfg_valid(cfg_valid), .cfg_ready(cfg_ready),
      .rb_start(rb_start), .rb_byte(rb_byte), .rb_valid(rb_valid), .rb_ready(rb_ready),
      .readback_data(rb_data), .readback_busy(rb_busy), .readback_aborted(rb_abort));
   always @(posedge clk_sys) begin
      if (cfg_valid === 1'b1 && cfg_ready === 1'b1) got.push_back(cfg_data);
      if (rb_abort === 1'b1) seen_abort <= 1'b1;
   end
   // sample well after each fall, before the next rise
   always @(negedge config_clock) begin
      #60;
      ch_sh = {ch_sh[6:0], chain_out};
      rb_sh = {rb_sh[6:0], rb_data};
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic fr(input logic [7:0] b, input int n, input bit slow);
      i_cps_host_model.frame(b, n, slow);
      // the last bit is sampled 60 ns after the final fall
      cyc(8);
   endtask
   task automatic pulse_restart();
      restart_n = 1'b0;
      cyc(6);
      chk("restart ready", {7'h0, ready}, 8'h00);
      restart_n = 1'b1;
      cyc(8);
   endtask
   task automatic t_async();
      logic [7:0] bytes[2] = '{8'ha5, 8'h3c};
      got.delete();
      foreach (bytes[k]) begin
         for (int i = 0; i < 400 && ready !== 1'b1; i++) cyc(1);
         data_in = bytes[k];
         cs_n = 1'b0;
         cs_hi = 1'b1;
         write_n = 1'b0;
         cyc(3);
         write_n = 1'b1;
         cyc(4);
         chk("ready busy", {7'h0, ready}, 8'h00);
         read_n = 1'b0;
         cyc(5);
         chk("bit7 enable", {7'h0, b7_oe_n}, 8'h00);
         chk("bit7 value", {7'h0, b7_out}, 8'h00);
         read_n = 1'b1;
         cs_n = 1'b1;
         cs_hi = 1'b0;
         cyc(5);
         chk("bit7 release", {7'h0, b7_oe_n}, 8'h01);
         fr(8'h00, 8, k[0]);
         chk("chain byte", ch_sh, bytes[k]);
      end
      for (int i = 0; i < 40 && ready !== 1'b1; i++) cyc(1);
      chk("ready back", {7'h0, ready}, 8'h01);
      cs_n = 1'b0;
      cs_hi = 1'b1;
      read_n = 1'b0;
      cyc(5);
      chk("bit7 ready", {7'h0, b7_out}, 8'h01);
      read_n = 1'b1;
      cs_n = 1'b1;
      cs_hi = 1'b0;
      chk("cfg async", got.size() == 2 ? got[1] : 8'hxx, 8'h3c);
   endtask
   task automatic t_serial();
      mode = cps_pkg::MODE_SERIAL;
      cyc(4);
      fr(8'hf0, 4, 0);
      pulse_restart();
      got.delete();
      fr(8'h96, 8, 1);
      chk("chain serial", ch_sh, 8'h96);
      cyc(6);
      chk("cfg serial", got.size() == 1 ? got[0] : 8'hxx, 8'h96);
   endtask
   task automatic t_parallel();
      mode = cps_pkg::MODE_PARALLEL;
      cfg_ready = 1'b0;
      pulse_restart();
      got.delete();
      cs_n = 1'b0;
      cs_hi = 1'b1;
      write_n = 1'b0;
      for (int k = 0; k < 7; k++) begin
         data_in = 8'h10 + 8'(k);
         fr(8'h00, 1, 0);
      end
      write_n = 1'b1;
      cs_n = 1'b1;
      cs_hi = 1'b0;
      cyc(4);
      chk("overflow", {7'h0, overflow}, 8'h01);
      chk("chain idle", {7'h0, chain_out}, 8'h01);
      cfg_ready = 1'b1;
      cyc(10);
      for (int k = 0; k < 4; k++) chk("cfg drain", got[k], 8'h10 + 8'(k));
      chk("drained", {7'h0, cfg_valid}, 8'h00);
      pulse_restart();
      chk("overflow clear", {7'h0, overflow}, 8'h00);
   endtask
   task automatic t_readback();
      rb_byte = 8'hc3;
      rb_valid = 1'b1;
      rb_start = 1'b1;
      cyc(1);
      rb_start = 1'b0;
      chk("rb ready", {7'h0, rb_ready}, 8'h01);
      cyc(2);
      fr(8'h00, 8, 0);
      chk("rb byte", rb_sh, 8'hc3);
      readback_ctrl = 1'b1;
      fr(8'h00, 1, 0);
      readback_ctrl = 1'b0;
      cyc(8);
      chk("short ctrl", {6'h0, seen_abort, rb_busy}, 8'h01);
      readback_ctrl = 1'b1;
      fr(8'h00, 2, 0);
      cyc(8);
      readback_ctrl = 1'b0;
      chk("aborted", {6'h0, seen_abort, rb_busy}, 8'h02);
      chk("rb idle", {7'h0, rb_data}, 8'h01);
   endtask
   task automatic end_of_test();
      if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      nrst = 1'b0;
      mode = cps_pkg::MODE_ASYNC;
      restart_n = 1'b1;
      cs_n = 1'b1;
      cs_hi = 1'b0;
      write_n = 1'b1;
      read_n = 1'b1;
      data_in = 8'h00;
      readback_ctrl = 1'b0;
      cfg_ready = 1'b1;
      rb_start = 1'b0;
      rb_byte = 8'h00;
      rb_valid = 1'b0;
      cyc(2);
      nrst = 1'b1;
      cyc(5);
      t_async();
      t_serial();
      t_parallel();
      t_readback();
      end_of_test();
   end
   // whole run is about 14 us; allow over twenty times that
   initial begin
      #300000;
      n_fail++;
      end_of_test();
   end
endmodule
